// [core/scs_clock_select.sv]
// What this block does
// - system clock runs from the external oscillator only with source code 001b.
// - external oscillator keeps clocking timers and counter array under internal clock.
// - source may change any time if the new source is enabled and running.
// - internal oscillators usable right after the write enabling them, no wait.
// - code 000 gives high-frequency oscillator over four, then the post-divider.
// - code 010 gives high-frequency oscillator over two; 011 undivided.
// - code 100 gives low-frequency oscillator over its divider; 101-111 reserved.
// - select register bits 6:4 read zero, written 000b; bit 7 reads zero.
// - after reset the high-frequency oscillator is the system clock source.
// - post-divider gives 1, 2, 4 or 8 after four, resets to 8.
// - suspend bit halts the oscillator and stops clocks derived from it.
// - any edge on the wake interrupt pin ends suspend.
// - after wake the CPU continues at the instruction after the suspend write.
// - seven-bit trim sets the period, zero fastest, all ones slowest.
// - trim resets to a per-part factory value giving 48 MHz.
// - trim register bit 7 reads zero and ignores writes.
// - post-divider 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// - control bit 7 enables the high-frequency oscillator, reset value 1.
`timescale 1ns/1ps
module scs_clock_select #(
  parameter logic [6:0] TRIM_RESET = 7'h40  // factory trim stand-in, value arbitrary
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // register port
  input  wire scs_pkg::scs_sfr_req_type sfr_req,
  output logic                    [7:0] sfr_rdata_q,
  // oscillator ticks
  input  wire logic                     hf_osc_tick,
  input  wire logic                     lf_osc_tick,
  input  wire logic                     ext_osc_tick,
  input  wire logic                     wake_interrupt_pin,
  // oscillator control
  output logic                          hf_osc_run_q,
  output logic                    [6:0] hf_osc_trim_q,
  // clocks to core, peripherals and crossbar
  output logic                          system_clock_pulse_q,
  output logic                          ext_periph_tick_q,
  output logic                          crossbar_clk_q,
  output logic                          cpu_halt_q
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0] code_q, code_d;
  logic       crossbar_clock_out_sync_q, crossbar_clock_out_sync_d;
  logic       hf_osc_enable_q, hf_osc_enable_d;
  logic       suspend_q, suspend_d;
  logic [1:0] hf_post_divider_q, hf_post_divider_d;
  logic       lf_en_q, lf_en_d;
  logic [1:0] lf_post_divider_q, lf_post_divider_d;
  logic [6:0] trim_d;
  logic [7:0] rdata_d;
  logic       wake_prev_q;
  logic       wake_edge;
  logic       wr_hfctl, wr_sel, suspend_set;

  assign wr_hfctl    = sfr_req.wr && (sfr_req.addr == scs_pkg::HFCTL_ADDR);
  assign wr_sel      = sfr_req.wr && (sfr_req.addr == scs_pkg::SEL_ADDR);
  assign suspend_set = wr_hfctl && sfr_req.wdata[scs_pkg::SUSPEND_BIT];
  // the wake pin is synchronous, so one stored copy is enough for the edge
  assign wake_edge   = wake_interrupt_pin ^ wake_prev_q;

  always_comb begin
    code_d                    = code_q;
    crossbar_clock_out_sync_d = crossbar_clock_out_sync_q;
    hf_osc_enable_d           = hf_osc_enable_q;
    hf_post_divider_d         = hf_post_divider_q;
    lf_en_d                   = lf_en_q;
    lf_post_divider_d         = lf_post_divider_q;
    trim_d                    = hf_osc_trim_q;
    suspend_d                 = suspend_q;
    if (suspend_q && wake_edge) begin
      suspend_d = 1'b0;
    end
    if (suspend_set) begin
      suspend_d = 1'b1;
    end
    if (wr_sel) begin
      code_d                    = sfr_req.wdata[2:0];
      crossbar_clock_out_sync_d = sfr_req.wdata[scs_pkg::CLKOUT_BIT];
    end
    if (wr_hfctl) begin
      hf_osc_enable_d   = sfr_req.wdata[scs_pkg::HF_EN_BIT];
      hf_post_divider_d = sfr_req.wdata[1:0];
    end
    if (sfr_req.wr && (sfr_req.addr == scs_pkg::LFCTL_ADDR)) begin
      lf_en_d           = sfr_req.wdata[scs_pkg::LF_EN_BIT];
      lf_post_divider_d = sfr_req.wdata[1:0];
    end
    // trim applies at once; changing it while running is the caller's hazard
    if (sfr_req.wr && (sfr_req.addr == scs_pkg::TRIM_ADDR)) begin
      trim_d = sfr_req.wdata[6:0];
    end
    rdata_d = sfr_rdata_q;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        scs_pkg::SEL_ADDR:    rdata_d = {4'h0, crossbar_clock_out_sync_q, code_q};
        // ready follows enable directly: no start-up wait
        scs_pkg::HFCTL_ADDR:  rdata_d = {hf_osc_enable_q, hf_osc_enable_q, suspend_q, 3'h0,
                                         hf_post_divider_q};
        scs_pkg::LFCTL_ADDR:  rdata_d = {lf_en_q, lf_en_q, 4'h0, lf_post_divider_q};
        scs_pkg::TRIM_ADDR:   rdata_d = {1'b0, hf_osc_trim_q};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      code_q                    <= scs_pkg::CODE_RESET;
      crossbar_clock_out_sync_q <= scs_pkg::CLKOUT_RESET;
      hf_osc_enable_q           <= scs_pkg::HF_EN_RESET;
      hf_post_divider_q         <= scs_pkg::HF_DIV_RESET;
      lf_en_q                   <= scs_pkg::LF_EN_RESET;
      lf_post_divider_q         <= scs_pkg::LF_DIV_RESET;
      hf_osc_trim_q             <= TRIM_RESET;
      suspend_q                 <= 1'b0;
      wake_prev_q               <= 1'b0;
      sfr_rdata_q               <= 8'h00;
    end else begin
      code_q                    <= code_d;
      crossbar_clock_out_sync_q <= crossbar_clock_out_sync_d;
      hf_osc_enable_q           <= hf_osc_enable_d;
      hf_post_divider_q         <= hf_post_divider_d;
      lf_en_q                   <= lf_en_d;
      lf_post_divider_q         <= lf_post_divider_d;
      hf_osc_trim_q             <= trim_d;
      suspend_q                 <= suspend_d;
      wake_prev_q               <= wake_interrupt_pin;
      sfr_rdata_q               <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // source selection and glitch-free switch
  // ----------------------------------------------------------------
  scs_pkg::scs_cfg_type     cfg_q, cfg_d, want_cfg;
  scs_pkg::scs_sw_state_type st_q, st_d;
  logic       hf_live, lf_live, src_tick, src_live, restart;
  logic [5:0] period;

  assign hf_live  = hf_osc_enable_q && !suspend_q;
  assign lf_live  = lf_en_q;
  assign want_cfg = '{code: code_q, hf_div: hf_post_divider_q, lf_div: lf_post_divider_q};

  always_comb begin
    src_tick = 1'b0;
    src_live = 1'b0;
    period   = scs_pkg::UNDIV_PERIOD;
    case (cfg_q.code)
      scs_pkg::SRC_HF_DIV4: begin
        src_tick = hf_osc_tick && hf_live;
        src_live = hf_live;
        period   = scs_pkg::HF_PRE_DIV << (2'h3 - cfg_q.hf_div);
      end
      scs_pkg::SRC_EXT: begin
        src_tick = ext_osc_tick;
        src_live = 1'b1;
      end
      scs_pkg::SRC_HF_DIV2: begin
        src_tick = hf_osc_tick && hf_live;
        src_live = hf_live;
        period   = scs_pkg::HF_DIV2_PERIOD;
      end
      scs_pkg::SRC_HF: begin
        src_tick = hf_osc_tick && hf_live;
        src_live = hf_live;
      end
      scs_pkg::SRC_LF: begin
        src_tick = lf_osc_tick && lf_live;
        src_live = lf_live;
        period   = scs_pkg::UNDIV_PERIOD << cfg_q.lf_div;
      end
      default: begin
        src_tick = 1'b0;
        src_live = 1'b0;
      end
    endcase
  end

  // a change waits for the old clock's edge, then the new one starts a full period;
  // an old internal source that is disabled or suspended is dropped at once; the external source is always waited for
  always_comb begin
    st_d    = st_q;
    cfg_d   = cfg_q;
    restart = 1'b0;
    case (st_q)
      scs_pkg::ST_RUN: begin
        // reserved codes are stored but never start a switch
        if ((want_cfg != cfg_q) && (code_q <= scs_pkg::SRC_LF)) begin
          st_d = scs_pkg::ST_SWITCH;
        end
      end
      scs_pkg::ST_SWITCH: begin
        if (system_clock_pulse_q || !src_live) begin
          cfg_d   = want_cfg;
          restart = 1'b1;
          st_d    = scs_pkg::ST_RUN;
        end
      end
      default: st_d = scs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q  <= scs_pkg::ST_RUN;
      cfg_q <= scs_pkg::CFG_RESET;
    end else begin
      st_q  <= st_d;
      cfg_q <= cfg_d;
    end
  end

  scs_tick_div #(.CW(6)) u_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick_in  (src_tick),
    .period   (period),
    .restart  (restart),
    .pulse_q  (system_clock_pulse_q)
  );

  // ----------------------------------------------------------------
  // outputs: peripherals, crossbar, CPU hold
  // ----------------------------------------------------------------
  logic xbar_raw_q, xbar_sync_q, hf_src;

  assign hf_src = (cfg_q.code == scs_pkg::SRC_HF_DIV4) || (cfg_q.code == scs_pkg::SRC_HF_DIV2) ||
                  (cfg_q.code == scs_pkg::SRC_HF);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xbar_raw_q        <= 1'b0;
      xbar_sync_q       <= 1'b0;
      crossbar_clk_q    <= 1'b0;
      ext_periph_tick_q <= 1'b0;
      hf_osc_run_q      <= 1'b0;
      cpu_halt_q        <= 1'b0;
    end else begin
      xbar_raw_q        <= xbar_raw_q ^ system_clock_pulse_q;
      xbar_sync_q       <= xbar_raw_q;
      crossbar_clk_q    <= crossbar_clock_out_sync_q ? xbar_sync_q : xbar_raw_q;
      ext_periph_tick_q <= ext_osc_tick;
      hf_osc_run_q      <= hf_osc_enable_d && !suspend_d;
      // the CPU holds state while halted, so it resumes after the suspend write
      cpu_halt_q        <= suspend_d && hf_src;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_SEL_UPPER_ZERO: assert property (
    (sfr_req.rd && sfr_req.addr == scs_pkg::SEL_ADDR) |=> (sfr_rdata_q[7:4] == 4'h0))
    else $error("select register upper bits not zero");
  AST_TRIM_TOP_ZERO: assert property (
    (sfr_req.rd && sfr_req.addr == scs_pkg::TRIM_ADDR) |=> !sfr_rdata_q[7])
    else $error("trim bit 7 not zero");
  AST_READY_AT_ONCE: assert property (
    (wr_hfctl && sfr_req.wdata[scs_pkg::HF_EN_BIT] && !suspend_q && !suspend_set)
    |=> (hf_live && hf_osc_run_q))
    else $error("oscillator not usable right after enable");
  AST_HF_UNDIV: assert property (
    (st_q == scs_pkg::ST_RUN && cfg_q.code == scs_pkg::SRC_HF && hf_osc_tick && hf_live)
    |=> system_clock_pulse_q)
    else $error("undivided clock missed a tick");
  AST_EXT_UNDIV: assert property (
    (st_q == scs_pkg::ST_RUN && cfg_q.code == scs_pkg::SRC_EXT && ext_osc_tick)
    |=> system_clock_pulse_q)
    else $error("external clock missed a tick");
  AST_RESERVED_HOLD: assert property (
    (st_q == scs_pkg::ST_RUN && code_q > scs_pkg::SRC_LF) |=> (cfg_q == $past(cfg_q)))
    else $error("reserved code took effect");
  AST_EXT_PERIPH: assert property (
    ext_osc_tick |=> ext_periph_tick_q)
    else $error("peripheral tick lost");
  AST_SUSPEND_SET: assert property (
    suspend_set |=> (suspend_q && !hf_osc_run_q))
    else $error("suspend write did not halt oscillator");
  AST_SUSPEND_NO_CLK: assert property (
    (suspend_q && hf_src) |=> !system_clock_pulse_q)
    else $error("clock ran while suspended");
  AST_WAKE: assert property (
    (suspend_q && wake_edge && !suspend_set) |=> (!suspend_q ##1 !cpu_halt_q))
    else $error("wake edge did not end suspend");
  AST_SWITCH_CLEAN: assert property (
    restart |=> !system_clock_pulse_q)
    else $error("short pulse after switch");
  AST_SWITCH_PEND: assert property (
    (st_q == scs_pkg::ST_SWITCH && !system_clock_pulse_q && src_live)
    |=> (cfg_q == $past(cfg_q)))
    else $error("switch taken mid period");

  COV_SWITCH: cover property (st_q == scs_pkg::ST_SWITCH ##[1:64] restart);
  COV_WAKE: cover property (suspend_q ##1 !suspend_q);
  COV_EXT: cover property (cfg_q.code == scs_pkg::SRC_EXT && system_clock_pulse_q);
  COV_LF: cover property (cfg_q.code == scs_pkg::SRC_LF && system_clock_pulse_q);

endmodule

// [core/scs_pkg.sv]
package scs_pkg;

  // ----------------------------------------------------------------
  // register addresses on the special-function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_ADDR    = 8'ha9;
  localparam logic [7:0] HFCTL_ADDR  = 8'hb2;
  localparam logic [7:0] TRIM_ADDR   = 8'hb3;
  localparam logic [7:0] LFCTL_ADDR  = 8'h86;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLKOUT_BIT  = 3;
  localparam int HF_EN_BIT   = 7;
  localparam int HF_RDY_BIT  = 6;
  localparam int SUSPEND_BIT = 5;
  localparam int LF_EN_BIT   = 7;
  localparam int LF_RDY_BIT  = 6;

  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_HF_DIV4 = 3'h0;
  localparam logic [2:0] SRC_EXT     = 3'h1;
  localparam logic [2:0] SRC_HF_DIV2 = 3'h2;
  localparam logic [2:0] SRC_HF      = 3'h3;
  localparam logic [2:0] SRC_LF      = 3'h4;

  // ----------------------------------------------------------------
  // divider periods, in source ticks
  // ----------------------------------------------------------------
  localparam logic [5:0] HF_PRE_DIV     = 6'h04;
  localparam logic [5:0] HF_DIV2_PERIOD = 6'h02;
  localparam logic [5:0] UNDIV_PERIOD   = 6'h01;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_RESET   = 3'h0;
  localparam logic       CLKOUT_RESET = 1'b0;
  localparam logic       HF_EN_RESET  = 1'b1;
  localparam logic [1:0] HF_DIV_RESET = 2'h0;
  localparam logic       LF_EN_RESET  = 1'b0;
  localparam logic [1:0] LF_DIV_RESET = 2'h0;

  typedef struct packed {
    logic [2:0] code;
    logic [1:0] hf_div;
    logic [1:0] lf_div;
  } scs_cfg_type;

  localparam scs_cfg_type CFG_RESET = '{code: CODE_RESET, hf_div: HF_DIV_RESET,
                                        lf_div: LF_DIV_RESET};

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scs_sfr_req_type;

  typedef enum logic [0:0] {ST_RUN, ST_SWITCH} scs_sw_state_type;

endpackage

// [core/scs_tick_div.sv]
`timescale 1ns/1ps
module scs_tick_div #(
  parameter int CW = 6
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          resetn,
  // source ticks and period
  input  wire logic          tick_in,
  input  wire logic [CW-1:0] period,
  input  wire logic          restart,
  // divided pulse
  output logic               pulse_q
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          pulse_d;

  // restart starts a full fresh period, so no short pulse follows a switch
  always_comb begin
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (restart) begin
      cnt_d = '0;
    end else if (tick_in) begin
      if (cnt_q >= period - CW'(1)) begin
        cnt_d   = '0;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

endmodule

// [tb/scs_clk_consumer.sv]
`timescale 1ns/1ps
module scs_clk_consumer #(
  parameter int EXT_P = 3,
  parameter int LF_P  = 5
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // from the block
  input  wire logic        hf_osc_run_q,
  input  wire logic        system_clock_pulse_q,
  // oscillator ticks
  output logic             hf_osc_tick,
  output logic             lf_osc_tick,
  output logic             ext_osc_tick,
  // measured system clock
  output logic      [15:0] gap,
  output logic      [15:0] pulses
);
  logic [15:0] cyc;
  int          n;

  initial begin
    hf_osc_tick  = 1'b0;
    lf_osc_tick  = 1'b0;
    ext_osc_tick = 1'b0;
    n            = 0;
  end

  // ----------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------
  // a halted oscillator gives no ticks at all, not a stale level
  always @(posedge core_clk) begin
    #1;
    n            = n + 1;
    hf_osc_tick  = hf_osc_run_q;
    lf_osc_tick  = (n % LF_P) == 0;
    ext_osc_tick = (n % EXT_P) == 0;
  end

  // ----------------------------------------------------------------
  // consumer: cycles between system clock edges
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cyc    <= 16'h0;
      gap    <= 16'h0;
      pulses <= 16'h0;
    end else if (system_clock_pulse_q) begin
      gap    <= cyc + 16'h1;
      cyc    <= 16'h0;
      pulses <= pulses + 16'h1;
    end else begin
      cyc <= cyc + 16'h1;
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] TRIM_RST = 7'h40;  // arbitrary factory stand-in
  localparam int         EXT_P    = 3;
  localparam int         LF_P     = 5;

  logic                     core_clk, resetn, wake, hf_t, lf_t, ext_t;
  logic                     run, sysp, extp, xclk, halt;
  logic               [7:0] rdata;
  logic               [6:0] trim;
  logic              [15:0] gap, pulses, p0;
  scs_pkg::scs_sfr_req_type req;
  int                       err_total, checked, i, c, d;

  scs_clock_select #(.TRIM_RESET(TRIM_RST)) scs_clock_select_inst (
    .core_clk(core_clk), .resetn(resetn), .sfr_req(req), .sfr_rdata_q(rdata),
    .hf_osc_tick(hf_t), .lf_osc_tick(lf_t), .ext_osc_tick(ext_t),
    .wake_interrupt_pin(wake), .hf_osc_run_q(run), .hf_osc_trim_q(trim),
    .system_clock_pulse_q(sysp), .ext_periph_tick_q(extp),
    .crossbar_clk_q(xclk), .cpu_halt_q(halt));

  scs_clk_consumer #(.EXT_P(EXT_P), .LF_P(LF_P)) scs_clk_consumer_inst (
    .core_clk(core_clk), .resetn(resetn), .hf_osc_run_q(run),
    .system_clock_pulse_q(sysp), .hf_osc_tick(hf_t), .lf_osc_tick(lf_t),
    .ext_osc_tick(ext_t), .gap(gap), .pulses(pulses));

  always #12.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge core_clk) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk) #1;
    req.wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk) #1;
    req.rd = 1'b0;
    @(posedge core_clk) #1;
    chk(16'(rdata), 16'(exp));
  endtask

  // expected system clock period in core cycles; hf ticks every cycle
  function automatic int per(int code, int hd, int ld);
    case (code)
      0:       per = 4 * (8 >> hd);
      1:       per = EXT_P;
      2:       per = 2;
      3:       per = 1;
      default: per = LF_P << ld;
    endcase
  endfunction

  // the gap between the 3rd and 4th pulse is clear of any switch, even one
  // that first lets an old pulse pass and then waits out an old period
  task automatic meas(int exp);
    p0 = pulses;
    for (c = 0; c < 400 && pulses < p0 + 16'h4; c++) begin
      @(posedge core_clk) #1;
    end
    chk(16'(c < 400), 16'h0001);
    chk(gap, exp[15:0]);
  endtask

  // crossbar output toggles two edges after a pulse, or three when resynced
  task automatic xb(logic sync);
    logic [2:0] ph;
    logic       xp, e;
    ph = 3'b000;
    xp = xclk;
    e  = 1'b0;
    for (d = 0; d < 40; d++) begin
      @(posedge core_clk) #2;
      if (d > 2) chk(16'(xclk ^ xp), 16'(sync ? ph[2] : ph[1]));
      if (d > 0) chk(16'(extp), 16'(e));
      ph = {ph[1:0], sysp};
      xp = xclk;
      e  = ext_t;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk  = 1'b0;
    resetn    = 1'b0;
    wake      = 1'b0;
    req       = '0;
    err_total = 0;
    checked   = 0;
    void'($urandom(32'h0393));
    repeat (10) @(posedge core_clk);
    #1 resetn = 1'b1;
    rd(8'ha9, 8'h00);
    rd(8'hb2, 8'hc0);
    rd(8'hb3, {1'b0, TRIM_RST});
    meas(32);
    wr(8'hb2, 8'h00);               // trim only while stopped
    wr(8'hb3, 8'hff);
    rd(8'hb3, 8'h7f);
    chk(16'(trim), 16'h007f);
    wr(8'hb3, 8'h00);
    chk(16'(trim), 16'h0000);
    rd(8'h55, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(8'hb2, 8'h80 | i[7:0]);
      meas(per(0, i, 0));
    end
    wr(8'h86, 8'h83);
    wr(8'ha9, 8'h04);               // selected right after enabling
    meas(per(4, 3, 3));
    rd(8'h86, 8'hc3);
    for (i = 1; i < 4; i++) begin
      wr(8'ha9, i[7:0]);
      meas(per(i, 3, 3));
    end
    wr(8'ha9, 8'h8d);               // reserved code, unused bit 7 set
    rd(8'ha9, 8'h0d);
    meas(1);
    wr(8'ha9, 8'h08);
    xb(1'b1);
    wr(8'ha9, 8'h00);
    xb(1'b0);
    for (i = 0; i < 2; i++) begin
      wr(8'hb2, 8'ha3);
      chk(16'(run), 16'h0000);
      chk(16'(halt), 16'h0001);
      // a pulse launched on the suspend edge itself is the last one
      @(posedge core_clk) #1;
      p0 = pulses;
      repeat (40) @(posedge core_clk);
      #1 chk(pulses, p0);
      wake = ~wake;
      repeat (2) @(posedge core_clk);
      #1 chk(16'(run), 16'h0001);
      chk(16'(halt), 16'h0000);
      rd(8'hb2, 8'hc3);
      meas(4);
    end
    for (i = 0; i < 12; i++) begin
      c = $urandom_range(4);
      d = $urandom_range(3);
      wr(8'hb2, 8'h80 | d[7:0]);
      wr(8'h86, 8'h80 | d[7:0]);
      wr(8'ha9, c[7:0] | 8'($urandom_range(1) << 3));
      meas(per(c, d, d));
    end
    conclude();
  end

  initial begin
    #(25 * 40000);
    err_total++;
    conclude();
  end
endmodule
